// file: omcc_ctrl.sv
// operating-mode and oscillator controller with avalon-mm register slave
//
// Function
// - halt bit 1 stops the fast oscillator; slow rc keeps running
// - slow select bit 2 picks high clock (0) or slow rc clock (1)
// - power state field 4:3: 00 normal, 01 sleep, 10 green, 11 reserved
// - halt acts on whichever fast source the configuration selects
// - wait 2048 slow rc periods of configuration before operation
// - after any reset wait 2048 fast oscillator cycles of warm-up
// - crystal wake from power down waits 2048 fast cycles
// - power down stops all oscillators, cpu and interrupts
// - timers and converter follow own enables except in power down
// - serial unit and uart unclocked in slow and green modes
// - green and power down wake on their own source sets
// - after reset release the device enters normal mode
// - wake from power down always returns to normal mode
// - wake from green returns to the mode it came from
// - selecting slow mode leaves the fast oscillator running
// - slow mode instruction rate is slow rc divided by 1, 2, 4, 8
// - sleep bit enters power down; wake clears it and sets wake flag
// - wake flag sticky until cleared; external irq wake leaves it clear
// - power down preserves all register contents
// - fast oscillator halted in normal mode acts as power down, port 1 wake
// - watchdog runs only by its configuration option
// - green bit enters green mode; wake clears it and sets wake flag
// - internal rc wake from power down waits 64 fast cycles
// - wake from green applies no warm-up
//
// Implementation choice: register access over Avalon-MM.
module omcc_ctrl #(
  parameter int P_SLOW_DIV   = omcc_pkg::SLOW_DIV,
  parameter int P_FAST_DIV   = omcc_pkg::FAST_DIV,
  parameter int P_CFG_TICKS  = omcc_pkg::CFG_TICKS,
  parameter int P_WARM_TICKS = omcc_pkg::WARM_TICKS,
  parameter int P_IRC_TICKS  = omcc_pkg::IRC_TICKS
) (
  input  wire logic                I_CLK,
  input  wire logic                I_RST,
  input  wire logic [9:0]          I_AVS_ADDRESS,
  input  wire logic                I_AVS_READ,
  input  wire logic                I_AVS_WRITE,
  input  wire logic [31:0]         I_AVS_WRITEDATA,
  input  wire logic [3:0]          I_AVS_BYTEENABLE,
  output logic [31:0]              O_AVS_READDATA,
  output logic                     O_AVS_WAITREQUEST,
  input  wire omcc_pkg::omcc_wake_s I_WAKE,
  output logic                     O_XTAL_EN,
  output logic                     O_FIRC_EN,
  output logic                     O_SLOW_OSC_EN,
  output logic                     O_SYS_CLK_SLOW,
  output logic                     O_CPU_TICK,
  output logic                     O_EXT_WAKE,
  output omcc_pkg::omcc_gate_s     O_GATES
);

  // ******************************************
  // declarations
  // ******************************************
  omcc_pkg::omcc_state_e state_q;
  omcc_pkg::omcc_state_e state_d;
  omcc_pkg::omcc_mode_s  mode_q;
  omcc_pkg::omcc_cfg_s   cfg_q;
  omcc_pkg::omcc_gate_s  gates_d;
  logic [11:0] cnt_q;
  logic [11:0] warm_lim;
  logic [2:0]  lcnt_q;
  logic        wake_q;
  logic        reset_warm_q;
  logic        noclk_q;
  logic        fast_tick;
  logic        slow_tick;
  logic        fast_on;
  logic        slow_on;
  logic        wake_green;
  logic        wake_down;
  logic        wake_any;
  logic        wake_plain;
  logic        wake_ext;
  logic        bus_req;
  logic        bus_done;
  logic        wr_mode;
  logic        wr_stat;
  logic        wr_cfg;
  logic [31:0] rd_d;
  logic        cpu_tick_d;

  // byte address of a register word index
  function automatic logic [9:0] word_addr(input logic [9:0] idx);
    word_addr = {idx[7:0], 2'b00};
  endfunction

  // ******************************************
  // oscillator models
  // ******************************************
  // power down stops everything; halt stops only the fast source
  assign fast_on = (state_q != omcc_pkg::ST_DOWN) && !mode_q.halt;
  assign slow_on = (state_q != omcc_pkg::ST_DOWN);

  omcc_tick_div #(.DIV(P_FAST_DIV)) u_fast (
    .i_clk  (I_CLK),
    .i_rst  (I_RST),
    .i_en   (fast_on),
    .o_tick (fast_tick)
  );

  omcc_tick_div #(.DIV(P_SLOW_DIV)) u_slow (
    .i_clk  (I_CLK),
    .i_rst  (I_RST),
    .i_en   (slow_on),
    .o_tick (slow_tick)
  );

  // ******************************************
  // avalon-mm slave
  // ******************************************
  // one wait state: a request is seen, then completed on the next edge
  assign bus_req  = I_AVS_READ || I_AVS_WRITE;
  assign bus_done = bus_req && !O_AVS_WAITREQUEST;
  assign wr_mode  = bus_done && I_AVS_WRITE && I_AVS_BYTEENABLE[0]
                    && (I_AVS_ADDRESS == word_addr(omcc_pkg::MODE_IDX));
  assign wr_stat  = bus_done && I_AVS_WRITE && I_AVS_BYTEENABLE[0]
                    && (I_AVS_ADDRESS == word_addr(omcc_pkg::STAT_IDX));
  assign wr_cfg   = bus_done && I_AVS_WRITE && I_AVS_BYTEENABLE[0]
                    && (I_AVS_ADDRESS == word_addr(omcc_pkg::CFG_IDX));

  // read mux; unmapped words read as zero
  always_comb begin
    rd_d = 32'h0000_0000;
    if (I_AVS_ADDRESS == word_addr(omcc_pkg::MODE_IDX)) begin
      rd_d[7:0] = {3'h0, mode_q.cpm, mode_q.slow_sel, mode_q.halt, 1'b0};
    end else if (I_AVS_ADDRESS == word_addr(omcc_pkg::STAT_IDX)) begin
      rd_d[7:0] = {3'h0, fast_on, 3'(state_q), wake_q};
    end else if (I_AVS_ADDRESS == word_addr(omcc_pkg::CFG_IDX)) begin
      rd_d[7:0] = {4'h0, cfg_q.wdt_en, cfg_q.low_div, cfg_q.xtal_sel};
    end
  end

  // waitrequest rests high so nothing completes before decode
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_AVS_WAITREQUEST <= 1'b1;
      O_AVS_READDATA    <= 32'h0000_0000;
    end else begin
      O_AVS_WAITREQUEST <= !(bus_req && O_AVS_WAITREQUEST);
      if (I_AVS_READ && O_AVS_WAITREQUEST) begin
        O_AVS_READDATA <= rd_d;
      end
    end
  end

  // ******************************************
  // wake detection
  // ******************************************
  assign wake_ext = I_WAKE.ext_irq_a || I_WAKE.ext_irq_b;

  // green takes timer 0 and converter too, plus usb transaction completion
  assign wake_green = (state_q == omcc_pkg::ST_GREEN) &&
                      (I_WAKE.p0_change || I_WAKE.p1_change || I_WAKE.tmr_ovf ||
                       I_WAKE.adc_done || wake_ext || I_WAKE.usb_bus_evt ||
                       I_WAKE.usb_xfer_done || I_WAKE.usb_pwr_det);

  // a halted clock in normal mode only listens to port 1
  assign wake_down = (state_q == omcc_pkg::ST_DOWN) &&
                     (noclk_q ? I_WAKE.p1_change :
                      (I_WAKE.p0_change || I_WAKE.p1_change || wake_ext ||
                       I_WAKE.usb_bus_evt || I_WAKE.usb_pwr_det));

  assign wake_any = wake_green || wake_down;

  // only an external interrupt wake leaves the wake flag alone
  assign wake_plain = wake_any && !(wake_ext && !(I_WAKE.p0_change || I_WAKE.p1_change ||
                      I_WAKE.tmr_ovf || I_WAKE.adc_done || I_WAKE.usb_bus_evt ||
                      I_WAKE.usb_xfer_done || I_WAKE.usb_pwr_det));

  // ******************************************
  // mode register
  // ******************************************
  // hardware clearing on wake is applied after a same-cycle write
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      mode_q <= omcc_pkg::MODE_RST;
    end else begin
      if (wr_mode) begin
        mode_q.halt     <= I_AVS_WRITEDATA[omcc_pkg::HALT_BIT];
        mode_q.slow_sel <= I_AVS_WRITEDATA[omcc_pkg::SLOW_BIT];
        if (I_AVS_WRITEDATA[omcc_pkg::CPM_LSB +: 2] != omcc_pkg::CPM_RSVD) begin
          mode_q.cpm <= I_AVS_WRITEDATA[omcc_pkg::CPM_LSB +: 2];
        end
      end
      if (wake_any) begin
        mode_q.cpm <= omcc_pkg::CPM_NORMAL;
      end
      if (wake_down) begin
        // restart the fast clock and come back in normal mode
        mode_q.slow_sel <= 1'b0;
        mode_q.halt     <= 1'b0;
      end
    end
  end

  // configuration options; reserved bits ignored
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      cfg_q <= omcc_pkg::CFG_RST;
    end else if (wr_cfg) begin
      cfg_q <= {4'h0, I_AVS_WRITEDATA[3:0]};
    end
  end

  // sticky wake flag, write one to clear; a new wake wins the clear
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      wake_q <= 1'b0;
    end else if (wake_plain) begin
      wake_q <= 1'b1;
    end else if (wr_stat && I_AVS_WRITEDATA[omcc_pkg::WAKE_BIT]) begin
      wake_q <= 1'b0;
    end
  end

  // ******************************************
  // mode sequencer
  // ******************************************
  // reset warm-up and crystal wake use the long count
  assign warm_lim = (reset_warm_q || cfg_q.xtal_sel) ? 12'(P_WARM_TICKS - 1)
                                                    : 12'(P_IRC_TICKS - 1);

  always_comb begin
    state_d = state_q;
    case (state_q)
      omcc_pkg::ST_CFG: begin
        if (slow_tick && cnt_q == 12'(P_CFG_TICKS - 1)) begin
          state_d = omcc_pkg::ST_WARM;
        end
      end
      omcc_pkg::ST_WARM: begin
        if (fast_tick && cnt_q == warm_lim) begin
          state_d = omcc_pkg::ST_RUN;
        end
      end
      omcc_pkg::ST_RUN: begin
        if (mode_q.cpm == omcc_pkg::CPM_SLEEP) begin
          state_d = omcc_pkg::ST_DOWN;
        end else if (mode_q.cpm == omcc_pkg::CPM_GREEN) begin
          state_d = omcc_pkg::ST_GREEN;
        end else if (mode_q.halt && !mode_q.slow_sel) begin
          state_d = omcc_pkg::ST_DOWN;
        end
      end
      omcc_pkg::ST_GREEN: begin
        if (wake_green) begin
          state_d = omcc_pkg::ST_RUN;
        end
      end
      omcc_pkg::ST_DOWN: begin
        if (wake_down) begin
          state_d = omcc_pkg::ST_WARM;
        end
      end
      default: begin
        state_d = omcc_pkg::ST_CFG;
      end
    endcase
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      state_q <= omcc_pkg::ST_CFG;
    end else begin
      state_q <= state_d;
    end
  end

  // wait counter restarts on every state change
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      cnt_q <= 12'h000;
    end else if (state_d != state_q) begin
      cnt_q <= 12'h000;
    end else if ((state_q == omcc_pkg::ST_CFG && slow_tick) ||
                 (state_q == omcc_pkg::ST_WARM && fast_tick)) begin
      cnt_q <= cnt_q + 12'h001;
    end
  end

  // remembers whether the warm-up follows a reset or a wake
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      reset_warm_q <= 1'b1;
    end else if (state_q == omcc_pkg::ST_WARM && state_d == omcc_pkg::ST_RUN) begin
      reset_warm_q <= 1'b0;
    end
  end

  // power down reached through a halted fast clock
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      noclk_q <= 1'b0;
    end else if (state_q == omcc_pkg::ST_RUN && state_d == omcc_pkg::ST_DOWN) begin
      noclk_q <= (mode_q.cpm != omcc_pkg::CPM_SLEEP);
    end
  end

  // ******************************************
  // instruction rate
  // ******************************************
  // slow rc ticks divided by 1, 2, 4 or 8
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      lcnt_q <= 3'h0;
    end else if (slow_tick) begin
      lcnt_q <= lcnt_q + 3'h1;
    end
  end

  always_comb begin
    cpu_tick_d = 1'b0;
    if (state_q == omcc_pkg::ST_RUN) begin
      if (mode_q.slow_sel) begin
        cpu_tick_d = slow_tick && ((lcnt_q & ((3'h1 << cfg_q.low_div) - 3'h1)) == 3'h0);
      end else begin
        cpu_tick_d = fast_tick;
      end
    end
  end

  // ******************************************
  // gates and outputs
  // ******************************************
  always_comb begin
    gates_d           = '0;
    gates_d.cpu_run   = (state_q == omcc_pkg::ST_RUN);
    gates_d.periph_en = (state_q == omcc_pkg::ST_RUN) ||
                        (state_q == omcc_pkg::ST_GREEN);
    gates_d.serial_en = (state_q == omcc_pkg::ST_RUN) && !mode_q.slow_sel;
    gates_d.irq_en    = (state_q == omcc_pkg::ST_RUN) ||
                        (state_q == omcc_pkg::ST_GREEN);
    gates_d.wdt_run   = cfg_q.wdt_en;
    gates_d.retain    = (state_q == omcc_pkg::ST_DOWN);
  end

  // every output leaves from a flip-flop
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_XTAL_EN      <= 1'b0;
      O_FIRC_EN      <= 1'b0;
      O_SLOW_OSC_EN  <= 1'b0;
      O_SYS_CLK_SLOW <= 1'b0;
      O_CPU_TICK     <= 1'b0;
      O_EXT_WAKE     <= 1'b0;
      O_GATES        <= '0;
    end else begin
      O_XTAL_EN      <= fast_on && cfg_q.xtal_sel;
      O_FIRC_EN      <= fast_on && !cfg_q.xtal_sel;
      O_SLOW_OSC_EN  <= slow_on;
      O_SYS_CLK_SLOW <= mode_q.slow_sel && (state_q == omcc_pkg::ST_RUN ||
                                            state_q == omcc_pkg::ST_GREEN);
      O_CPU_TICK     <= cpu_tick_d;
      O_EXT_WAKE     <= wake_any && wake_ext;
      O_GATES        <= gates_d;
    end
  end

  // ******************************************
  // checks
  // ******************************************
  AST_SLEEP_ENTER: assert property (@(posedge I_CLK) disable iff (I_RST)
    state_q == omcc_pkg::ST_RUN && mode_q.cpm == omcc_pkg::CPM_SLEEP |=> state_q == omcc_pkg::ST_DOWN)
    else $error("sleep request did not enter power down");

  AST_GREEN_ENTER: assert property (@(posedge I_CLK) disable iff (I_RST)
    state_q == omcc_pkg::ST_RUN && mode_q.cpm == omcc_pkg::CPM_GREEN |=> state_q == omcc_pkg::ST_GREEN)
    else $error("green request did not enter green mode");

  AST_DOWN_STOPS: assert property (@(posedge I_CLK) disable iff (I_RST)
    state_q == omcc_pkg::ST_DOWN |=> !O_XTAL_EN && !O_FIRC_EN && !O_SLOW_OSC_EN && !O_GATES.irq_en)
    else $error("clocks or interrupts alive in power down");

  AST_DOWN_WAKE: assert property (@(posedge I_CLK) disable iff (I_RST)
    wake_down |=> state_q == omcc_pkg::ST_WARM && !mode_q.slow_sel && mode_q.cpm == omcc_pkg::CPM_NORMAL)
    else $error("power down wake did not return toward normal mode");

  AST_GREEN_BACK: assert property (@(posedge I_CLK) disable iff (I_RST)
    wake_green |=> state_q == omcc_pkg::ST_RUN && mode_q.slow_sel == $past(mode_q.slow_sel))
    else $error("green wake changed the previous mode");

  AST_WAKE_FLAG: assert property (@(posedge I_CLK) disable iff (I_RST)
    wake_any && !wake_ext |=> wake_q)
    else $error("wake flag not set on wake");

  AST_EXT_NOFLAG: assert property (@(posedge I_CLK) disable iff (I_RST)
    wake_any && !wake_plain && !wake_q |=> !wake_q && O_EXT_WAKE)
    else $error("external wake touched the wake flag");

  AST_RSVD_CODE: assert property (@(posedge I_CLK) disable iff (I_RST)
    wr_mode && I_AVS_WRITEDATA[4:3] == omcc_pkg::CPM_RSVD && !wake_any |=> mode_q.cpm == $past(mode_q.cpm))
    else $error("reserved power state code was stored");

  AST_HALT_STOP: assert property (@(posedge I_CLK) disable iff (I_RST)
    mode_q.halt |=> !O_XTAL_EN && !O_FIRC_EN)
    else $error("fast oscillator enabled while halted");

  AST_SERIAL_OFF: assert property (@(posedge I_CLK) disable iff (I_RST)
    (state_q == omcc_pkg::ST_RUN && mode_q.slow_sel) || state_q == omcc_pkg::ST_GREEN |=> !O_GATES.serial_en)
    else $error("serial clock on in slow or green mode");

  AST_WDT_OPT: assert property (@(posedge I_CLK) disable iff (I_RST)
    1'b1 |=> O_GATES.wdt_run == $past(cfg_q.wdt_en))
    else $error("watchdog run differs from its option");

endmodule // omcc_ctrl

// file: omcc_ctrl_bench.sv
// self-checking bench of the operating-mode clock controller
module omcc_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // shortened counts and register addresses
  // ****************************************
  localparam int SDIV = 4, FDIV = 2, CFGT = 4, WARMT = 8, IRCT = 2;
  localparam logic [9:0] A_MODE = 10'h254, A_STAT = 10'h258, A_CFG = 10'h25C;
  localparam logic [8:0] W_P0 = 9'h100, W_P1 = 9'h080, W_TMR = 9'h040, W_XFER = 9'h002;
  logic                 I_CLK = 1'b0, I_RST = 1'b1, I_AVS_READ = 1'b0, I_AVS_WRITE = 1'b0;
  logic [9:0]           I_AVS_ADDRESS = 10'h000;
  logic [31:0]          I_AVS_WRITEDATA = 32'h0, O_AVS_READDATA;
  logic [3:0]           I_AVS_BYTEENABLE = 4'hF;
  logic                 O_AVS_WAITREQUEST, O_XTAL_EN, O_FIRC_EN, O_SLOW_OSC_EN, O_SYS_CLK_SLOW, O_CPU_TICK, O_EXT_WAKE;
  omcc_pkg::omcc_wake_s I_WAKE = '0;
  omcc_pkg::omcc_gate_s O_GATES;
  int                   failures = 0, num_checks = 0, cyc = 0, ext_cnt = 0;

  omcc_ctrl #(.P_SLOW_DIV(SDIV), .P_FAST_DIV(FDIV), .P_CFG_TICKS(CFGT), .P_WARM_TICKS(WARMT),
    .P_IRC_TICKS(IRCT)) i_omcc_ctrl (.I_CLK(I_CLK), .I_RST(I_RST), .I_AVS_ADDRESS(I_AVS_ADDRESS),
    .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE), .I_AVS_WRITEDATA(I_AVS_WRITEDATA),
    .I_AVS_BYTEENABLE(I_AVS_BYTEENABLE), .O_AVS_READDATA(O_AVS_READDATA),
    .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .I_WAKE(I_WAKE), .O_XTAL_EN(O_XTAL_EN),
    .O_FIRC_EN(O_FIRC_EN), .O_SLOW_OSC_EN(O_SLOW_OSC_EN), .O_SYS_CLK_SLOW(O_SYS_CLK_SLOW),
    .O_CPU_TICK(O_CPU_TICK), .O_EXT_WAKE(O_EXT_WAKE), .O_GATES(O_GATES));

  // 125 MHz clock
  always #4 I_CLK = ~I_CLK;

  // cycle count, external wake pulses and hang guard
  always @(posedge I_CLK) begin
    cyc <= cyc + 1;
    if (O_EXT_WAKE === 1'b1) ext_cnt <= ext_cnt + 1;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end

  task automatic results;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_val({31'h0, got}, {31'h0, exp});
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge I_CLK);
  endtask

  // one avalon cycle; an idle edge follows so strobes never re-rise in the same step
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] wd, input logic [3:0] be,
                     output logic [31:0] rd);
    I_AVS_ADDRESS <= a;
    I_AVS_WRITEDATA <= {24'h0, wd};
    I_AVS_BYTEENABLE <= be;
    I_AVS_WRITE <= w;
    I_AVS_READ <= ~w;
    do @(posedge I_CLK); while (O_AVS_WAITREQUEST !== 1'b0);
    rd = O_AVS_READDATA;
    I_AVS_WRITE <= 1'b0;
    I_AVS_READ <= 1'b0;
    @(posedge I_CLK);
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, 4'hF, x);
  endtask

  task automatic chk_reg(input logic [9:0] a, input logic [7:0] e);
    logic [31:0] d;
    bus(1'b0, a, 8'h00, 4'hF, d);
    chk_val(d, {24'h0, e});
  endtask

  // status: state code in 3:1, wake flag in 0
  task automatic chk_stat(input logic [2:0] s, input logic f);
    logic [31:0] d;
    bus(1'b0, A_STAT, 8'h00, 4'hF, d);
    chk_val({28'h0, d[3:0]}, {28'h0, s, f});
  endtask

  task automatic wait_run(output int n);
    logic [31:0] d;
    int t_st;
    t_st = cyc;
    do bus(1'b0, A_STAT, 8'h00, 4'hF, d); while (d[3:1] !== 3'h2);
    n = cyc - t_st;
  endtask

  task automatic wake(input logic [8:0] w);
    I_WAKE <= omcc_pkg::omcc_wake_s'(w);
    @(posedge I_CLK);
    I_WAKE <= '0;
    idle(2);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    int n;
    wait_run(n);
    chk_bit(n >= (CFGT - 1) * SDIV + (WARMT - 1) * FDIV, 1'b1);
    chk_reg(A_MODE, 8'h00);
    chk_reg(A_CFG, 8'h09);
    chk_val({26'h0, O_GATES}, 32'h3E);
  endtask

  task automatic t_regs;
    logic [31:0] x;
    wr(A_MODE, 8'h18);
    chk_reg(A_MODE, 8'h00);
    chk_stat(3'h2, 1'b0);
    bus(1'b1, A_MODE, 8'h04, 4'hE, x);
    chk_reg(A_MODE, 8'h00);
    wr(10'h260, 8'hFF);
    chk_reg(10'h260, 8'h00);
    wr(A_MODE, 8'h04);
    idle(3);
    chk_val({O_SYS_CLK_SLOW, O_XTAL_EN, O_GATES.serial_en}, 3'h6);
    wr(A_MODE, 8'h06);
    idle(3);
    chk_val({O_XTAL_EN, O_SLOW_OSC_EN}, 2'h1);
    wr(A_CFG, 8'h08);
    idle(3);
    chk_val({O_XTAL_EN, O_FIRC_EN}, 2'h0);
    wr(A_MODE, 8'h04);
    idle(3);
    chk_val({O_XTAL_EN, O_FIRC_EN}, 2'h1);
    wr(A_CFG, 8'h09);
  endtask

  // instruction tick spacing in slow mode for every divider
  task automatic t_rate;
    int t1;
    for (int d = 0; d < 4; d++) begin
      wr(A_CFG, 8'h09 | 8'(d << 1));
      wr(A_MODE, 8'h04);
      idle(3);
      do @(posedge I_CLK); while (O_CPU_TICK !== 1'b1);
      t1 = cyc;
      do @(posedge I_CLK); while (O_CPU_TICK !== 1'b1);
      chk_val(32'(cyc - t1), 32'(SDIV << d));
    end
    wr(A_CFG, 8'h09);
    wr(A_MODE, 8'h00);
  endtask

  // each of the nine wake inputs tried in one low-power mode
  task automatic t_srcs(input logic [7:0] mode, input logic [8:0] ok);
    logic [31:0] d;
    int n;
    for (int i = 0; i < 9; i++) begin
      wr(A_MODE, mode);
      idle(3);
      wake(9'(1 << i));
      bus(1'b0, A_STAT, 8'h00, 4'hF, d);
      chk_bit(d[3:1] == 3'h4 || d[3:1] == 3'h3, ~ok[i]);
      if (!ok[i]) wake(W_P1);
      wait_run(n);
      chk_stat(3'h2, !(i == 3 || i == 4));
      wr(A_STAT, 8'h01);
    end
  endtask

  task automatic t_down(input logic [7:0] cfg, input logic [7:0] ent, input int warm);
    int n;
    wr(A_CFG, cfg);
    wr(A_MODE, ent);
    idle(3);
    chk_val({26'h0, O_GATES}, {28'h0, cfg[3], 1'b1});
    chk_val({O_XTAL_EN, O_FIRC_EN, O_SLOW_OSC_EN, O_GATES.cpu_run}, 4'h0);
    wake(W_XFER);
    chk_stat(3'h4, 1'b0);
    wake(W_P1);
    wait_run(n);
    chk_bit(n >= (warm - 2) * FDIV && n <= (warm + 2) * FDIV + 8, 1'b1);
    chk_reg(A_MODE, 8'h00);
    chk_reg(A_CFG, cfg);
    wr(A_STAT, 8'h01);
    chk_stat(3'h2, 1'b0);
  endtask

  task automatic t_green;
    wr(A_MODE, 8'h14);
    idle(3);
    chk_val({O_GATES.cpu_run, O_GATES.periph_en, O_SYS_CLK_SLOW}, 3'h3);
    wake(W_TMR);
    chk_stat(3'h2, 1'b1);
    chk_reg(A_MODE, 8'h04);
    // back in slow mode the fast source must still be running
    chk_val({O_XTAL_EN, O_SYS_CLK_SLOW}, 2'h3);
    wr(A_MODE, 8'h00);
    wr(A_STAT, 8'h01);
  endtask

  task automatic t_halt;
    int n;
    wr(A_MODE, 8'h02);
    idle(3);
    wake(W_P0);
    chk_stat(3'h4, 1'b0);
    wake(W_P1);
    wait_run(n);
    chk_stat(3'h2, 1'b1);
    wr(A_STAT, 8'h01);
  endtask

  // main sequence
  initial begin
    idle(2);
    I_RST <= 1'b0;
    @(posedge I_CLK);
    t_reset();
    t_regs();
    t_rate();
    t_srcs(8'h10, 9'h1FF);
    t_srcs(8'h08, 9'h19D);
    chk_val(32'(ext_cnt), 32'h4);
    t_down(8'h09, 8'h0C, WARMT);
    t_down(8'h00, 8'h08, IRCT);
    wr(A_CFG, 8'h09);
    t_green();
    t_halt();
    results();
  end
endmodule // omcc_ctrl_bench

// file: omcc_pkg.sv
// constants, types and register map of the operating-mode clock controller
package omcc_pkg;

  // ******************************************
  // register map (word index, byte address = index * 4)
  // ******************************************
  localparam logic [9:0] MODE_IDX = 10'h095;
  localparam logic [9:0] STAT_IDX = 10'h096;
  localparam logic [9:0] CFG_IDX  = 10'h097;

  // field positions
  localparam int HALT_BIT = 1;
  localparam int SLOW_BIT = 2;
  localparam int CPM_LSB  = 3;
  localparam int WAKE_BIT = 0;

  // values after reset
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CFG_RST  = 8'h09;

  // cpu power state codes
  localparam logic [1:0] CPM_NORMAL = 2'h0;
  localparam logic [1:0] CPM_SLEEP  = 2'h1;
  localparam logic [1:0] CPM_GREEN  = 2'h2;
  localparam logic [1:0] CPM_RSVD   = 2'h3;

  // ******************************************
  // rates and cycle counts
  // ******************************************
  localparam int CLK_KHZ  = 125000;
  localparam int FAST_KHZ = 16000;
  localparam int SLOW_KHZ = 32;
  // oscillator period in system clocks, rounded up
  localparam int FAST_DIV = (CLK_KHZ + FAST_KHZ - 1) / FAST_KHZ;
  localparam int SLOW_DIV = (CLK_KHZ + SLOW_KHZ - 1) / SLOW_KHZ;
  // oscillator cycles of each wait
  localparam int CFG_TICKS  = 2048;
  localparam int WARM_TICKS = 2048;
  localparam int IRC_TICKS  = 64;

  // ******************************************
  // types
  // ******************************************
  typedef enum logic [2:0] {ST_CFG, ST_WARM, ST_RUN, ST_GREEN, ST_DOWN} omcc_state_e;

  typedef struct packed {
    logic [2:0] rsv_hi;
    logic [1:0] cpm;
    logic       slow_sel;
    logic       halt;
    logic       rsv_lo;
  } omcc_mode_s;

  typedef struct packed {
    logic [3:0] rsv;
    logic       wdt_en;
    logic [1:0] low_div;
    logic       xtal_sel;
  } omcc_cfg_s;

  typedef struct packed {
    logic p0_change;
    logic p1_change;
    logic tmr_ovf;
    logic adc_done;
    logic ext_irq_a;
    logic ext_irq_b;
    logic usb_bus_evt;
    logic usb_xfer_done;
    logic usb_pwr_det;
  } omcc_wake_s;

  typedef struct packed {
    logic cpu_run;
    logic periph_en;
    logic serial_en;
    logic irq_en;
    logic wdt_run;
    logic retain;
  } omcc_gate_s;

endpackage

// file: omcc_tick_div.sv
// oscillator model: one-cycle tick every DIV system clocks while enabled
module omcc_tick_div #(
  parameter int DIV = 8
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_en,
  output logic      o_tick
);

  localparam int W = $clog2(DIV + 1);

  logic [W-1:0] cnt_q;

  // a stopped oscillator restarts its phase from zero
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q  <= '0;
      o_tick <= 1'b0;
    end else if (!i_en) begin
      cnt_q  <= '0;
      o_tick <= 1'b0;
    end else if (cnt_q == W'(DIV - 1)) begin
      cnt_q  <= '0;
      o_tick <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 1'b1;
      o_tick <= 1'b0;
    end
  end

endmodule // omcc_tick_div
